// >>> csc_clock_stop_ctrl.sv
// Clock divider, stretch control and halt/wait sequencing.
`timescale 1ns/1ns
`include "csc_defines.svh"

module csc_clock_stop_ctrl
#(
  parameter int STACK_CYCLES = 7
)
(
  // Clock and reset; mclk is the oscillator input.
  input wire logic mclk,
  input wire logic srst,
  // Oscillator output, always held low; no crystal drive.
  output logic osc_out,
  // System clock and control pins from outside.
  output logic sys_clk,
  input wire logic slow_memory_hold,
  input wire logic stop_req_n,
  input wire logic irq_n,
  // Sequencer interface from the instruction engine.
  input wire logic instr_end,
  input wire logic sleep_fetch_done,
  input wire logic vector_fetch_done,
  input wire logic [15:0] next_addr,
  // Bus status and interrupt accept outputs.
  output logic bus_released,
  output logic address_valid,
  output logic [15:0] addr_out,
  output logic irq_take
);
  import csc_pkg::*;

  initial
  begin
    if (STACK_CYCLES < 1 || STACK_CYCLES > 255)
      $error("STACK_CYCLES out of range");
  end

  // Pin synchronisers, two flops each.
  logic [1:0] hold_s1_reg, stop_s1_reg, irq_s1_reg;
  logic hold_reg, stop_n_reg, irq_n_reg;
  always_ff @(posedge mclk)
  begin
    hold_s1_reg <= {hold_s1_reg[0], slow_memory_hold};
    stop_s1_reg <= {stop_s1_reg[0], stop_req_n};
    irq_s1_reg <= {irq_s1_reg[0], irq_n};
  end
  assign hold_reg = hold_s1_reg[1];
  assign stop_n_reg = stop_s1_reg[1];
  assign irq_n_reg = irq_s1_reg[1];

  // Phase counter and clock register next values.
  logic [1:0] phase_reg, phase_next;
  logic clk_reg, clk_next;
  logic stall_reg, stall_next;
  logic phase_step;
  always_comb
  begin
    phase_next = phase_reg;
    stall_next = 1'b0;
    phase_step = 1'b1;
    // stretch half period
    // A low hold stalls at a half-period boundary; every stall lasts two
    // oscillator cycles, so the clock only ever grows by whole half periods.
    if (phase_reg[0] && (!hold_reg || stall_reg))
    begin
      phase_step = 1'b0;
      stall_next = !stall_reg;
    end
    if (phase_step)
      phase_next = phase_reg + 2'h1;
    clk_next = (phase_next >= `CSC_PHASE_HIGH);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      phase_reg <= `CSC_PHASE_RST;
      clk_reg <= 1'b0;
      stall_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      clk_reg <= clk_next;
      stall_reg <= stall_next;
    end
  end

  assign sys_clk = clk_reg;
  // oscillator output left idle with an external clock.
  assign osc_out = 1'b0;

  // Cycle boundary: end of a system clock period.
  logic cyc_end;
  assign cyc_end = (phase_reg == 2'h3) && phase_step;

  // Sequencer state.
  csc_state_type state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic irq_pend_reg, irq_pend_next;
  logic take_reg, take_next;
  logic [15:0] addr_reg, addr_next;
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    take_next = 1'b0;
    addr_next = addr_reg;
    irq_pend_next = irq_pend_reg;
    if (state_reg != CSC_HALT)
      addr_next = next_addr;
    case (state_reg)
      CSC_RUN:
      begin
        if (sleep_fetch_done)
        begin
          state_next = CSC_STACK;
          cnt_next = 8'(STACK_CYCLES);
        end
        else if (instr_end && !stop_n_reg)
          state_next = CSC_HALT;
        else if (instr_end && irq_pend_reg)
        begin
          take_next = 1'b1;
          irq_pend_next = 1'b0;
        end
      end
      CSC_STACK:
      begin
        if (cyc_end)
        begin
          cnt_next = cnt_reg - 8'h1;
          if (cnt_reg == 8'h1)
            state_next = CSC_WAIT;
        end
      end
      CSC_WAIT:
      begin
        if (irq_pend_reg)
        begin
          take_next = 1'b1;
          irq_pend_next = 1'b0;
          state_next = CSC_VECTOR;
        end
      end
      CSC_VECTOR:
      begin
        if (vector_fetch_done)
          state_next = stop_n_reg ? CSC_RUN : CSC_HALT;
      end
      CSC_HALT:
      begin
        if (stop_n_reg)
          state_next = CSC_RUN;
      end
      default:
        state_next = CSC_RUN;
    endcase
    // latch interrupts
    // A request still present wins over the clear of an accepted one.
    if (!irq_n_reg)
      irq_pend_next = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_reg <= CSC_RUN;
      cnt_reg <= 8'h0;
      irq_pend_reg <= 1'b0;
      take_reg <= 1'b0;
      addr_reg <= 16'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      irq_pend_reg <= irq_pend_next;
      take_reg <= take_next;
      addr_reg <= addr_next;
    end
  end

  assign bus_released = (state_reg == CSC_HALT) || (state_reg == CSC_WAIT);
  assign address_valid = !bus_released;
  assign addr_out = addr_reg;
  assign irq_take = take_reg;

  // Assertions.
  property p_div4;
    @(posedge mclk) disable iff (srst)
    $rose(clk_reg) && hold_reg ##1 hold_reg[*3] |=> $rose(clk_reg);
  endproperty
  a_div4: assert property (p_div4) else $error("clock period wrong");

  property p_stretch;
    @(posedge mclk) disable iff (srst)
    (phase_reg[0] && !hold_reg) |=> $stable(clk_reg);
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch failed");

  property p_normal;
    @(posedge mclk) disable iff (srst)
    hold_reg && !stall_reg |=> phase_reg != $past(phase_reg);
  endproperty
  a_normal: assert property (p_normal) else $error("clock stalled");

  property p_halt_bus;
    @(posedge mclk) disable iff (srst)
    state_reg == CSC_HALT |-> bus_released && !address_valid
      && (($past(state_reg) != CSC_HALT) || $stable(addr_out));
  endproperty
  a_halt_bus: assert property (p_halt_bus) else $error("halt bus wrong");

  property p_halt_entry;
    @(posedge mclk) disable iff (srst)
    state_reg == CSC_RUN && !sleep_fetch_done && instr_end && !stop_n_reg
      |=> state_reg == CSC_HALT;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("no halt");

  property p_sleep_ignore;
    @(posedge mclk) disable iff (srst)
    state_reg == CSC_STACK |=> state_reg inside {CSC_STACK, CSC_WAIT};
  endproperty
  a_sleep_ignore: assert property (p_sleep_ignore) else $error("stop taken");

  property p_wake;
    @(posedge mclk) disable iff (srst)
    state_reg == CSC_WAIT && irq_pend_reg |=> state_reg == CSC_VECTOR && irq_take;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed");

  property p_vec_halt;
    @(posedge mclk) disable iff (srst)
    state_reg == CSC_VECTOR && vector_fetch_done && !stop_n_reg
      |=> state_reg == CSC_HALT;
  endproperty
  a_vec_halt: assert property (p_vec_halt) else $error("no halt after vector");

  property p_latch;
    @(posedge mclk) disable iff (srst)
    !irq_n_reg && state_reg == CSC_HALT |=> irq_pend_reg && !irq_take;
  endproperty
  a_latch: assert property (p_latch) else $error("irq lost in halt");

  property p_wait_ba;
    @(posedge mclk) disable iff (srst)
    state_reg == CSC_WAIT |-> bus_released && !address_valid
      && ($past(state_reg) inside {CSC_STACK, CSC_WAIT});
  endproperty
  a_wait_ba: assert property (p_wait_ba) else $error("wait without release");

  c_halt: cover property (@(posedge mclk) state_reg == CSC_HALT);
  c_wait: cover property (@(posedge mclk) state_reg == CSC_WAIT);
  c_vec_halt: cover property (@(posedge mclk)
    state_reg == CSC_VECTOR ##1 state_reg == CSC_HALT);
endmodule

// >>> csc_clock_stop_ctrl_bench.sv
// Self-checking bench for the clock and stop control block.
`timescale 1ns/1ns
module csc_clock_stop_ctrl_bench;
  logic mclk = 0, srst = 1, want_hold = 0, want_stop = 0, want_irq = 0;
  logic instr_end = 0, sleep_fetch_done = 0, vector_fetch_done = 0;
  logic [15:0] next_addr = 16'h0, addr_out, held;
  logic [31:0] seed = 32'h525c;
  logic sys_clk, slow_memory_hold, stop_req_n, irq_n, bus_released, address_valid, irq_take;
  int fail_count = 0, comparisons = 0, takes = 0, edges, odd, n;
  // Oscillator input that never stops.
  // free running clock
  initial
  begin
    forever #2 mclk = !mclk;
  end
  // The oscillator output is left open.
  // external clock mode
  csc_clock_stop_ctrl #(.STACK_CYCLES(2)) uut (.mclk(mclk), .srst(srst), .osc_out(),
    .sys_clk(sys_clk), .slow_memory_hold(slow_memory_hold), .stop_req_n(stop_req_n),
    .irq_n(irq_n), .instr_end(instr_end), .sleep_fetch_done(sleep_fetch_done),
    .vector_fetch_done(vector_fetch_done), .next_addr(next_addr),
    .bus_released(bus_released), .address_valid(address_valid), .addr_out(addr_out),
    .irq_take(irq_take));
  csc_sys_partner sys (.mclk(mclk), .want_hold(want_hold), .want_stop(want_stop),
    .want_irq(want_irq), .slow_memory_hold(slow_memory_hold), .stop_req_n(stop_req_n),
    .irq_n(irq_n));
  // Counts accepted interrupts.
  always @(posedge mclk)
  begin
    if (irq_take === 1'b1)
      takes++;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Waits for the released level, then checks both status pins.
  task automatic wait_br(logic v);
    n = 0;
    while (bus_released !== v && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
    check("bus_released", {15'h0, bus_released}, {15'h0, v});
    check("address_valid", {15'h0, address_valid}, {15'h0, !v});
    // A level that never came is already counted by the checks above.
    if (bus_released !== v)
      end_sim();
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge mclk);
    s = 0;
  endtask
  // Counts clock changes and odd-length complete runs.
  task automatic measure(int len);
    logic prev;
    int run;
    prev = sys_clk;
    run = 0;
    edges = 0;
    odd = 0;
    repeat (len)
    begin
      @(negedge mclk);
      run++;
      if (sys_clk !== prev)
      begin
        odd += (edges > 0) ? run % 2 : 0;
        edges++;
        run = 0;
        prev = sys_clk;
      end
    end
  endtask
  // Main sequence.
  initial
  begin
    repeat (6) @(negedge mclk);
    srst = 0;
    check("sys_clk", {15'h0, sys_clk}, 16'h0);
    check("addr_out", addr_out, 16'h0);
    measure(64);
    check("edges", 16'(edges), 16'h20);
    check("odd", 16'(odd), 16'h0);
    fork
      measure(96);
      begin
        repeat (10) @(negedge mclk);
        want_hold = 1;
        repeat (8 + rnd() % 32) @(negedge mclk);
        want_hold = 0;
      end
    join
    check("stretched", 16'(edges < 48), 16'h1);
    check("odd", 16'(odd), 16'h0);
    want_stop = 1;
    next_addr = rnd();
    held = next_addr;
    repeat (4) @(negedge mclk);
    pulse(instr_end);
    wait_br(1);
    next_addr = rnd();
    want_irq = 1;
    repeat (6) @(negedge mclk);
    check("addr_out", addr_out, held);
    check("takes", 16'(takes), 16'h0);
    // The request goes away together with stop, so only the latch can deliver it.
    want_irq = 0;
    want_stop = 0;
    wait_br(0);
    pulse(instr_end);
    repeat (4) @(negedge mclk);
    check("takes", 16'(takes), 16'h1);
    pulse(instr_end);
    repeat (4) @(negedge mclk);
    check("takes", 16'(takes), 16'h1);
    // Sleep with stop high, then with stop low.
    for (int s = 0; s < 2; s++)
    begin
      pulse(sleep_fetch_done);
      want_stop = s[0];
      check("stacking", {15'h0, bus_released}, 16'h0);
      wait_br(1);
      want_irq = 1;
      n = takes;
      repeat (8) @(negedge mclk);
      check("takes", 16'(takes - n), 16'h1);
      check("vector", {15'h0, bus_released}, 16'h0);
      want_irq = 0;
      pulse(vector_fetch_done);
      repeat (4) @(negedge mclk);
      wait_br(s[0]);
      want_stop = 0;
      wait_br(0);
      // Drains an interrupt latched while the request was still low.
      pulse(instr_end);
      repeat (4) @(negedge mclk);
    end
    end_sim();
  end
endmodule

// >>> csc_defines.svh
// Timing and phase constants for the clock and stop control block.
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH
// Oscillator to system clock divide ratio.
`define CSC_DIV_RATIO 4
// Phase count at which the system clock goes high, and its reset value.
`define CSC_PHASE_HIGH 2'h2
`define CSC_PHASE_RST 2'h0
// Longest stretch the partner may apply, in nanoseconds.
`define CSC_MAX_STRETCH_NS 4500
`define CSC_CLK_NS 4
`define CSC_MAX_STRETCH_CYC (`CSC_MAX_STRETCH_NS / `CSC_CLK_NS)
`endif

// >>> csc_pkg.sv
// Types shared by the clock and stop control block.
package csc_pkg;
  typedef enum logic [2:0]
  {
    CSC_RUN = 3'h0,
    CSC_STACK = 3'h1,
    CSC_WAIT = 3'h2,
    CSC_VECTOR = 3'h3,
    CSC_HALT = 3'h4
  } csc_state_type;
endpackage

// >>> csc_sys_partner.sv
// System side model driving the hold, stop and interrupt pins.
`timescale 1ns/1ns
`include "csc_defines.svh"
module csc_sys_partner
(
  // Clock and wishes from the bench.
  input wire logic mclk,
  input wire logic want_hold,
  input wire logic want_stop,
  input wire logic want_irq,
  // Pins toward the block.
  output logic slow_memory_hold = 1'b1,
  output logic stop_req_n = 1'b1,
  output logic irq_n = 1'b1
);
  int hold_cnt = 0;
  // Pins move on the falling edge; a stretch is cut at its limit.
  // bounded stretch
  always @(negedge mclk)
  begin
    hold_cnt = want_hold ? hold_cnt + 1 : 0;
    slow_memory_hold <= !(want_hold && hold_cnt < `CSC_MAX_STRETCH_CYC);
    stop_req_n <= !want_stop;
    irq_n <= !want_irq;
  end
endmodule
